// ### core/ehr_error_history.sv
// Error history store with sequential readout over the drive parameter port.
`timescale 1ns/1ps

module ehr_error_history (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Parameter access port.
    input wire logic [15:0] par_addr_i,
    input wire logic par_wr_i,
    input wire logic par_rd_i,
    input wire logic [31:0] par_wdata_i,
    output logic [31:0] par_rdata_o,
    output logic par_rvalid_o,
    // New error record from the monitoring logic.
    input wire logic rec_valid_i,
    input wire logic [15:0] rec_code_i,
    input wire logic [15:0] rec_class_i,
    input wire logic [31:0] rec_time_i,
    input wire logic [15:0] rec_qual_i,
    input wire logic [15:0] rec_en_cyc_i,
    input wire logic [15:0] rec_en_dur_i,
    input wire logic [15:0] rec_udc_i,
    input wire logic [15:0] rec_vel_i,
    input wire logic [15:0] rec_cur_i,
    input wire logic [15:0] rec_t_stage_i,
    input wire logic [15:0] rec_t_dev_i,
    // Power-on cycle count from the non-volatile counter.
    input wire logic [31:0] power_on_cycles_i
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // A command write hits when the strobe, offset and value all match.
    function automatic logic ehr_cmd_hit(input logic wr, input logic [15:0] addr,
                                         input logic [15:0] offs, input logic [31:0] data);
        ehr_cmd_hit = wr && (addr == offs) && (data == ehr_pkg::CMD_VALUE);
    endfunction

    // Widen a 16-bit field into the low half of a read word.
    function automatic logic [31:0] ehr_low16(input logic [15:0] v);
        ehr_low16 = {16'h0000, v};
    endfunction

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------

    // The entry array and its fill count carry no reset: they stand for the
    // retained store, so only the clear command ever empties them.
    ehr_pkg::ehr_entry_type entries_r [ehr_pkg::DEPTH];
    logic [3:0] count_r;
    ehr_pkg::ehr_entry_type hold_r;
    logic [3:0] ptr_r;
    ehr_pkg::ehr_clr_type clr_state_r;
    logic [3:0] clr_idx_r;
    logic [31:0] rdata_nxt;

    ehr_pkg::ehr_entry_type new_entry;
    logic rec_take;
    logic full;
    logic avail;
    logic code_rd;
    logic ptr_cmd;
    logic clr_cmd;
    logic clr_busy;
    logic clr_last;

    assign clr_busy = (clr_state_r == ehr_pkg::CLR_RUN);
    assign clr_last = clr_busy && (clr_idx_r == ehr_pkg::LAST_POS);
    assign full = (count_r == ehr_pkg::DEPTH_CNT);
    assign avail = (ptr_r < count_r);
    assign code_rd = par_rd_i && (par_addr_i == ehr_pkg::ADDR_CODE);
    assign ptr_cmd = ehr_cmd_hit(par_wr_i, par_addr_i, ehr_pkg::ADDR_PTR_RESET, par_wdata_i);
    assign clr_cmd = ehr_cmd_hit(par_wr_i, par_addr_i, ehr_pkg::ADDR_CLEAR, par_wdata_i);
    // Records arriving while a clear sweeps the array are dropped on purpose,
    // since a half-cleared history would otherwise hold a misplaced entry.
    assign rec_take = rec_valid_i && !clr_busy;

    // ------------------------------------------------------------------
    // Incoming record formatting
    // ------------------------------------------------------------------

    // Class is clamped to 4 and time to its ceiling on the way in.
    always_comb
    begin
        new_entry.code = rec_code_i;
        new_entry.err_class = (rec_class_i > ehr_pkg::CLASS_MAX) ? ehr_pkg::CLASS_MAX : rec_class_i;
        new_entry.det_time = (rec_time_i > ehr_pkg::TIME_MAX) ? ehr_pkg::TIME_MAX : rec_time_i;
        new_entry.qual = rec_qual_i;
        new_entry.en_cyc = rec_en_cyc_i;
        new_entry.en_dur = rec_en_dur_i;
        new_entry.udc = rec_udc_i;
        new_entry.vel = rec_vel_i;
        new_entry.cur = rec_cur_i;
        new_entry.t_stage = rec_t_stage_i;
        new_entry.t_dev = rec_t_dev_i;
    end

    // ------------------------------------------------------------------
    // Entry array
    // ------------------------------------------------------------------

    // Each slot is cleared by the sweep, appended at the fill level, or takes
    // its younger neighbour (the top slot takes the new record) when a record lands on a full history.
    genvar gi;
    generate
        for (gi = 0; gi < ehr_pkg::DEPTH; gi++)
        begin : g_slot
            // The shift source is chosen at elaboration so the top slot never
            // names a neighbour beyond the end of the array.
            ehr_pkg::ehr_entry_type shift_in;
            if (gi == ehr_pkg::DEPTH - 1)
            begin : g_top
                assign shift_in = new_entry;
            end
            else
            begin : g_mid
                assign shift_in = entries_r[gi + 1];
            end

            always_ff @(posedge clk_i)
            begin
                if (clr_busy && (clr_idx_r == 4'(gi)))
                begin
                    entries_r[gi] <= '0;
                end
                else if (rec_take && full)
                begin
                    entries_r[gi] <= shift_in;
                end
                else if (rec_take && (count_r == 4'(gi)))
                begin
                    entries_r[gi] <= new_entry;
                end
            end
        end
    endgenerate

    // Fill count: grows to ten and stays there; the clear sweep ends at zero.
    always_ff @(posedge clk_i)
    begin
        if (clr_last)
        begin
            count_r <= 4'h0;
        end
        else if (rec_take && !full)
        begin
            count_r <= count_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Clear sequencer
    // ------------------------------------------------------------------

    // One slot per cycle keeps the sweep to a single write port on the store.
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            clr_state_r <= ehr_pkg::CLR_IDLE;
            clr_idx_r <= 4'h0;
        end
        else
        begin
            case (clr_state_r)
                ehr_pkg::CLR_IDLE:
                begin
                    if (clr_cmd)
                    begin
                        clr_state_r <= ehr_pkg::CLR_RUN;
                        clr_idx_r <= 4'h0;
                    end
                end
                ehr_pkg::CLR_RUN:
                begin
                    if (clr_last)
                    begin
                        clr_state_r <= ehr_pkg::CLR_IDLE;
                        clr_idx_r <= 4'h0;
                    end
                    else
                    begin
                        clr_idx_r <= clr_idx_r + 4'h1;
                    end
                end
                default:
                begin
                    clr_state_r <= ehr_pkg::CLR_IDLE;
                    clr_idx_r <= 4'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read pointer and holding buffer
    // ------------------------------------------------------------------

    // The pointer only steps forward or returns to the oldest entry, so there
    // is no way to address an arbitrary position.
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            ptr_r <= 4'h0;
        end
        else if (ptr_cmd || clr_last)
        begin
            ptr_r <= 4'h0;
        end
        else if (code_rd && avail)
        begin
            ptr_r <= ptr_r + 4'h1;
        end
    end

    // An exhausted read leaves an empty buffer so stale details never show.
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            hold_r <= '0;
        end
        else if (code_rd)
        begin
            hold_r <= avail ? entries_r[ptr_r] : '0;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------

    // Detail reads serve the holding buffer; unmapped offsets read as zero.
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        case (par_addr_i)
            ehr_pkg::ADDR_POWER_ON: rdata_nxt = power_on_cycles_i;
            ehr_pkg::ADDR_CLEAR: rdata_nxt = clr_busy ? ehr_pkg::CLR_BUSY_VALUE : 32'h00000000;
            ehr_pkg::ADDR_PTR_RESET: rdata_nxt = 32'h00000000;
            ehr_pkg::ADDR_CODE: rdata_nxt = ehr_low16(avail ? entries_r[ptr_r].code : ehr_pkg::CODE_NONE);
            ehr_pkg::ADDR_CLASS: rdata_nxt = ehr_low16(hold_r.err_class);
            ehr_pkg::ADDR_TIME: rdata_nxt = hold_r.det_time;
            ehr_pkg::ADDR_QUAL: rdata_nxt = ehr_low16(hold_r.qual);
            ehr_pkg::ADDR_EN_CYC: rdata_nxt = ehr_low16(hold_r.en_cyc);
            ehr_pkg::ADDR_EN_DUR: rdata_nxt = ehr_low16(hold_r.en_dur);
            ehr_pkg::ADDR_UDC: rdata_nxt = ehr_low16(hold_r.udc);
            ehr_pkg::ADDR_VEL: rdata_nxt = ehr_low16(hold_r.vel);
            ehr_pkg::ADDR_CUR: rdata_nxt = ehr_low16(hold_r.cur);
            ehr_pkg::ADDR_T_STAGE: rdata_nxt = ehr_low16(hold_r.t_stage);
            ehr_pkg::ADDR_T_DEV: rdata_nxt = ehr_low16(hold_r.t_dev);
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Read answer is registered one cycle after the strobe.
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            par_rdata_o <= 32'h00000000;
            par_rvalid_o <= 1'b0;
        end
        else
        begin
            par_rvalid_o <= par_rd_i;
            par_rdata_o <= par_rd_i ? rdata_nxt : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Pointer moves only by one step forward or back to zero.
    property p_ptr_seq;
        (ptr_r != $past(ptr_r)) |-> ((ptr_r == $past(ptr_r) + 4'h1) || (ptr_r == 4'h0));
    endproperty
    a_ptr_seq: assert property (p_ptr_seq) else $error("read pointer jumped");

    property p_ptr_reset;
        ptr_cmd |=> (ptr_r == 4'h0);
    endproperty
    a_ptr_reset: assert property (p_ptr_reset) else $error("pointer reset not applied");

    property p_code_advance;
        (code_rd && avail && !ptr_cmd && !clr_last) |=> (ptr_r == $past(ptr_r) + 4'h1) && par_rvalid_o;
    endproperty
    a_code_advance: assert property (p_code_advance) else $error("code read did not advance");

    property p_code_end;
        (code_rd && !avail) |=> (par_rdata_o == 32'h00000000) && (hold_r.code == 16'h0000);
    endproperty
    a_code_end: assert property (p_code_end) else $error("end of history not zero");

    // An exhausted read leaves the pointer where it stands.
    property p_code_end_hold;
        (code_rd && !avail && !ptr_cmd && !clr_last) |=> $stable(ptr_r);
    endproperty
    a_code_end_hold: assert property (p_code_end_hold) else $error("pointer moved past the end");

    // The code answered and the code latched for the details belong to one entry.
    property p_code_latch;
        (code_rd && avail) |=> (par_rdata_o[15:0] == hold_r.code);
    endproperty
    a_code_latch: assert property (p_code_latch) else $error("latched entry differs from code read");

    property p_append;
        (rec_take && !full) |=> (count_r == $past(count_r) + 4'h1);
    endproperty
    a_append: assert property (p_append) else $error("record not appended");

    property p_newest_last;
        (rec_take && full) |=> full && (entries_r[ehr_pkg::DEPTH - 1].code == $past(rec_code_i));
    endproperty
    a_newest_last: assert property (p_newest_last) else $error("newest not in last slot");

    property p_class_range;
        (par_rd_i && par_addr_i == ehr_pkg::ADDR_CLASS) |=> (par_rdata_o <= 32'h00000004);
    endproperty
    a_class_range: assert property (p_class_range) else $error("class out of range");

    property p_time_range;
        (par_rd_i && par_addr_i == ehr_pkg::ADDR_TIME) |=> (par_rdata_o <= ehr_pkg::TIME_MAX);
    endproperty
    a_time_range: assert property (p_time_range) else $error("time above ceiling");

    // The sweep length is counted in helper logic rather than unrolled as a
    // ten-fold repetition, which would slow the checking tools badly.
    logic [3:0] sweep_len_r;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !clr_busy)
        begin
            sweep_len_r <= 4'h0;
        end
        else
        begin
            sweep_len_r <= sweep_len_r + 4'h1;
        end
    end

    // A clear command starts the sweep at once and empties the history ten cycles later.
    property p_clear_run;
        (clr_cmd && !clr_busy) |=> clr_busy ##10 (!clr_busy && count_r == 4'h0 && ptr_r == 4'h0);
    endproperty
    a_clear_run: assert property (p_clear_run) else $error("clear sweep length wrong");

    // Busy stands without a gap for the whole sweep, one cycle per slot.
    property p_clear_len;
        (clr_busy ##1 !clr_busy) |-> (sweep_len_r == ehr_pkg::DEPTH_CNT);
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear busy span wrong");

    property p_clear_read;
        (par_rd_i && par_addr_i == ehr_pkg::ADDR_CLEAR) |=> ((par_rdata_o != 32'h00000000) == $past(clr_busy));
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("clear status read wrong");

    // Negated match, so the unset fill count before the first clear does not fire.
    property p_count_cap;
        not (count_r > ehr_pkg::DEPTH_CNT);
    endproperty
    a_count_cap: assert property (p_count_cap) else $error("history over ten");

    c_full_shift: cover property (rec_take && full);
    c_clear_done: cover property (clr_busy ##1 !clr_busy);
    c_read_end: cover property (code_rd && !avail && count_r != 4'h0);
    c_ptr_rewind: cover property (ptr_cmd && ptr_r != 4'h0);

endmodule // ehr_error_history

// ### core/ehr_pkg.sv
// Constants, entry layout and parameter offsets of the error history readout.
package ehr_pkg;

    // ------------------------------------------------------------------
    // Geometry and limits
    // ------------------------------------------------------------------
    localparam int DEPTH = 10;
    localparam logic [3:0] DEPTH_CNT = 4'ha;
    localparam logic [3:0] LAST_POS = 4'h9;
    localparam logic [15:0] CLASS_MAX = 16'h0004;
    localparam logic [31:0] TIME_MAX = 32'h1fffffff;
    localparam logic [31:0] CMD_VALUE = 32'h00000001;
    localparam logic [31:0] CLR_BUSY_VALUE = 32'h00000001;
    localparam logic [15:0] CODE_NONE = 16'h0000;

    // ------------------------------------------------------------------
    // Parameter offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_POWER_ON = 16'h3b04;
    localparam logic [15:0] ADDR_CLEAR = 16'h3b08;
    localparam logic [15:0] ADDR_PTR_RESET = 16'h3b0a;
    localparam logic [15:0] ADDR_CODE = 16'h3c02;
    localparam logic [15:0] ADDR_CLASS = 16'h3c04;
    localparam logic [15:0] ADDR_TIME = 16'h3c06;
    localparam logic [15:0] ADDR_QUAL = 16'h3c08;
    localparam logic [15:0] ADDR_EN_CYC = 16'h3c0a;
    localparam logic [15:0] ADDR_EN_DUR = 16'h3c0c;
    localparam logic [15:0] ADDR_UDC = 16'h3c0e;
    localparam logic [15:0] ADDR_VEL = 16'h3c10;
    localparam logic [15:0] ADDR_CUR = 16'h3c12;
    localparam logic [15:0] ADDR_T_STAGE = 16'h3c14;
    localparam logic [15:0] ADDR_T_DEV = 16'h3c16;

    // ------------------------------------------------------------------
    // One stored history entry
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] code;
        logic [15:0] err_class;
        logic [31:0] det_time;
        logic [15:0] qual;
        logic [15:0] en_cyc;
        logic [15:0] en_dur;
        logic [15:0] udc;
        logic [15:0] vel;
        logic [15:0] cur;
        logic [15:0] t_stage;
        logic [15:0] t_dev;
    } ehr_entry_type;

    typedef enum logic [0:0] {
        CLR_IDLE = 1'b0,
        CLR_RUN = 1'b1
    } ehr_clr_type;

endpackage

// ### tb/ehr_master_model.sv
// Fieldbus master model that issues parameter reads and writes to the history.
`timescale 1ns/1ps

module ehr_master_model (
    // Clock.
    input wire logic clk_i,
    // Parameter port towards the history.
    output logic [15:0] par_addr_o,
    output logic par_wr_o,
    output logic par_rd_o,
    output logic [31:0] par_wdata_o,
    input wire logic [31:0] par_rdata_i,
    input wire logic par_rvalid_i
);
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------

    // Idle port at time zero.
    initial
    begin
        par_addr_o = 16'h0000;
        par_wr_o = 1'b0;
        par_rd_o = 1'b0;
        par_wdata_o = 32'h00000000;
    end

    // One write; released lines show the inverse so a stale value never passes for a held one.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk_i);
        par_addr_o = a;
        par_wdata_o = d;
        par_wr_o = 1'b1;
        @(negedge clk_i);
        par_wr_o = 1'b0;
        par_addr_o = ~a;
        par_wdata_o = ~d;
    endtask

    // One read; the answer stands one cycle after the strobe edge, so it is taken mid-cycle.
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
        @(negedge clk_i);
        par_addr_o = a;
        par_rd_o = 1'b1;
        @(negedge clk_i);
        par_rd_o = 1'b0;
        par_addr_o = ~a;
        d = par_rdata_i;
        v = par_rvalid_i;
    endtask
endmodule // ehr_master_model

// ### tb/error_history_readout_tb.sv
// Self-checking bench for the error history readout.
`timescale 1ns/1ps

module error_history_readout_tb;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [15:0] par_addr;
    logic par_wr;
    logic par_rd;
    logic [31:0] par_wdata;
    logic [31:0] par_rdata;
    logic par_rvalid;
    logic rec_valid = 1'b0;
    ehr_pkg::ehr_entry_type rec = '0;
    logic [31:0] power_on = 32'h00000000;
    int miscompares = 0;
    int num_checks = 0;
    ehr_pkg::ehr_entry_type exp_q[$];
    localparam logic [15:0] DET_ADDR [11] = '{ehr_pkg::ADDR_CODE, ehr_pkg::ADDR_CLASS, ehr_pkg::ADDR_TIME,
        ehr_pkg::ADDR_QUAL, ehr_pkg::ADDR_EN_CYC, ehr_pkg::ADDR_EN_DUR, ehr_pkg::ADDR_UDC, ehr_pkg::ADDR_VEL,
        ehr_pkg::ADDR_CUR, ehr_pkg::ADDR_T_STAGE, ehr_pkg::ADDR_T_DEV};

    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;

    ehr_error_history u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .par_addr_i(par_addr), .par_wr_i(par_wr), .par_rd_i(par_rd), .par_wdata_i(par_wdata),
        .par_rdata_o(par_rdata), .par_rvalid_o(par_rvalid),
        .rec_valid_i(rec_valid), .rec_code_i(rec.code), .rec_class_i(rec.err_class),
        .rec_time_i(rec.det_time), .rec_qual_i(rec.qual), .rec_en_cyc_i(rec.en_cyc),
        .rec_en_dur_i(rec.en_dur), .rec_udc_i(rec.udc), .rec_vel_i(rec.vel), .rec_cur_i(rec.cur),
        .rec_t_stage_i(rec.t_stage), .rec_t_dev_i(rec.t_dev), .power_on_cycles_i(power_on)
    );

    ehr_master_model u_master (
        .clk_i(clk_i), .par_addr_o(par_addr), .par_wr_o(par_wr), .par_rd_o(par_rd),
        .par_wdata_o(par_wdata), .par_rdata_i(par_rdata), .par_rvalid_i(par_rvalid)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    // Read and compare; every read must be answered the cycle after its strobe.
    task automatic rdc(input logic [15:0] a, input logic [31:0] expv);
        logic [31:0] d;
        logic v;
        u_master.rd(a, d, v);
        chk({31'h0, v}, 32'h1);
        chk(d, expv);
    endtask

    function automatic logic [31:0] field(input ehr_pkg::ehr_entry_type e, input int k);
        logic [191:0] b;
        b = e;
        if (k == 2)
            return b[159:128];
        return {16'h0000, (k < 2) ? b[191 - 16 * k -: 16] : b[175 - 16 * k -: 16]};
    endfunction

    // Record one error; the expectation applies the class and time ceilings.
    task automatic put(input logic [7:0] n, input logic [15:0] cls, input logic [31:0] tm, input bit keep);
        ehr_pkg::ehr_entry_type e;
        @(negedge clk_i);
        rec = {8'h10, n, cls, tm, {n, 8'h01}, {n, 8'h02}, {n, 8'h03}, {n, 8'h04}, {~n, 8'h05}, {n, 8'h06},
               {~n, 8'h07}, {~n, 8'h08}};
        rec_valid = 1'b1;
        e = rec;
        if (e.err_class > ehr_pkg::CLASS_MAX)
            e.err_class = ehr_pkg::CLASS_MAX;
        if (e.det_time > ehr_pkg::TIME_MAX)
            e.det_time = ehr_pkg::TIME_MAX;
        @(negedge clk_i);
        rec_valid = 1'b0;
        if (keep)
            exp_q.push_back(e);
        if (exp_q.size() > ehr_pkg::DEPTH)
            exp_q.pop_front();
    endtask

    // Rewind, walk the whole history oldest first, then expect the end marker.
    task automatic readout();
        u_master.wr(ehr_pkg::ADDR_PTR_RESET, ehr_pkg::CMD_VALUE);
        foreach (exp_q[i])
            for (int k = 0; k < 11; k++)
                rdc(DET_ADDR[k], field(exp_q[i], k));
        rdc(ehr_pkg::ADDR_CODE, 32'h0);
    endtask

    // Clear and poll for completion; a record may be offered while the clear runs.
    task automatic clear_all(input bit rec_during);
        logic [31:0] d;
        logic v;
        u_master.wr(ehr_pkg::ADDR_CLEAR, ehr_pkg::CMD_VALUE);
        if (rec_during)
            put(8'h40, 16'h0001, 32'h00000010, 1'b0);
        else
            rdc(ehr_pkg::ADDR_CLEAR, ehr_pkg::CLR_BUSY_VALUE);
        d = 32'h1;
        for (int i = 0; i < 20 && d !== 32'h0; i++)
            u_master.rd(ehr_pkg::ADDR_CLEAR, d, v);
        chk(d, 32'h0);
        exp_q.delete();
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (6) @(negedge clk_i);
        reset_n_i = 1'b1;
        clear_all(1'b0);
        readout();
        $display("test empty history done");
        put(8'h00, 16'h0000, 32'h00000000, 1'b1);
        put(8'h01, 16'h0007, 32'hffffffff, 1'b1);
        put(8'h02, 16'h0004, 32'h1fffffff, 1'b1);
        readout();
        rdc(ehr_pkg::ADDR_CODE, 32'h0);
        readout();
        $display("test short history done");
        for (int n = 3; n < 14; n++)
            put(8'(n), 16'(n % 5), 32'(n * 1000), 1'b1);
        readout();
        $display("test full history done");
        // Retained storage must outlive a mid-run reset.
        @(negedge clk_i);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        reset_n_i = 1'b1;
        readout();
        $display("test reset retention done");
        u_master.wr(ehr_pkg::ADDR_CODE, 32'h00005555);
        u_master.wr(ehr_pkg::ADDR_CLEAR, 32'h00000002);
        rdc(ehr_pkg::ADDR_CLEAR, 32'h0);
        rdc(16'h3d00, 32'h0);
        rdc(ehr_pkg::ADDR_PTR_RESET, 32'h0);
        power_on = 32'hffffffff;
        rdc(ehr_pkg::ADDR_POWER_ON, 32'hffffffff);
        power_on = 32'h00012345;
        rdc(ehr_pkg::ADDR_POWER_ON, 32'h00012345);
        readout();
        $display("test refused accesses done");
        clear_all(1'b1);
        readout();
        $display("test clear with record done");
        finish_test();
    end

    // Watchdog: the tests need under a thousand cycles, so this span only trips on a hang.
    initial
    begin
        repeat (30000) @(posedge clk_i);
        miscompares++;
        finish_test();
    end
endmodule // error_history_readout_tb
